// file: hdl/lccf_ctrl.sv
/*
 * APB register bank and output filter for one limit comparator channel.
 * Assumes a zero-wait APB master on clk and a raw comparator result that is
 * asynchronous to clk; the analog core and reference DAC sit outside.
 */
// Function
// - A write that sets both mode selects keeps the sampling select and clears the window select.
// - Bit 5 of control register one is read-only zero and ignores writes.
// - The speed bit selects low-speed comparison at zero and high-speed at one.
// - The polarity bit passes the result at zero and inverts it at one.
// - With pin drive zero the polarity bit is shown as output on the pin and status bit.
// - The output source select is stuck at zero so the output is the filtered result.
// - The pin drive bit is stuck at zero so the output never drives its pin.
// - The enable bit turns the comparator off at zero and on at one.
// - With sampling select zero the period field sets bus cycles between filter samples.
// - With sampling select zero, a filter period of zero disables the output filter.
// - With sampling select one the period is ignored and the external strobe samples.
// - A new output state is taken after the programmed count of agreeing samples, zero is off; with sampling select one a zero count holds the output at zero.
`timescale 1ns/10ps
`include "lccf_consts.svh"

module lccf_ctrl #(
   parameter int ADDR_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic raw_result,
   input wire logic sample_strobe,
   output logic filtered_result,
   output logic comparator_pin_output,
   output logic comparator_pin_oe,
   output logic comparator_enable,
   output logic high_speed_mode,
   output logic window_mode,
   output logic hysteresis_level
);
   import lccf_pkg::*;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   wire logic [13:0] word_idx = paddr[15:2];
   wire logic access = psel && penable;
   wire logic wr_lane = access && pwrite && pstrb[0];
   wire logic hit_cr0 = (word_idx == `LCCF_IDX_CTRL_ZERO);
   wire logic hit_cr1 = (word_idx == `LCCF_IDX_CTRL_ONE);
   wire logic hit_fpr = (word_idx == `LCCF_IDX_FILT_PER);
   wire logic hit_scr = (word_idx == `LCCF_IDX_STAT_CTRL);
   wire logic hit_any = hit_cr0 || hit_cr1 || hit_fpr || hit_scr;
   wire logic wr_cr0 = wr_lane && hit_cr0;
   wire logic wr_cr1 = wr_lane && hit_cr1;
   wire logic wr_fpr = wr_lane && hit_fpr;

   lccf_byte_t cr0_q;
   lccf_byte_t cr1_q;
   lccf_byte_t fpr_q;
   lccf_byte_t cr1_d;
   lccf_byte_t cr0_d;
   lccf_byte_t scr_rd;
   lccf_byte_t rd_byte;

   // Writable bits only; source select, pin drive and bit 5 never store.
   wire logic wr_sample = pwdata[`LCCF_CR1_SAMPLE];
   wire logic wr_window = pwdata[`LCCF_CR1_WINDOW] && !wr_sample;
   assign cr1_d = {wr_sample, wr_window, 1'b0,
                   pwdata[`LCCF_CR1_SPEED], pwdata[`LCCF_CR1_INVERT],
                   1'b0, 1'b0,
                   pwdata[`LCCF_CR1_ENABLE]};
   assign cr0_d = {1'b0, pwdata[`LCCF_CR0_CNT_MSB:`LCCF_CR0_CNT_LSB], 3'b000,
                   pwdata[`LCCF_CR0_HYST]};

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cr0_q <= `LCCF_RESET_BYTE;
         cr1_q <= `LCCF_RESET_BYTE;
         fpr_q <= `LCCF_RESET_BYTE;
      end
      else
      begin
         if (wr_cr0)
            cr0_q <= cr0_d;
         if (wr_cr1)
            cr1_q <= cr1_d;
         if (wr_fpr)
            fpr_q <= pwdata[7:0];
      end
   end

   // ****************************************************************
   // Control fields
   // ****************************************************************
   wire logic en = cr1_q[`LCCF_CR1_ENABLE];
   wire logic invert = cr1_q[`LCCF_CR1_INVERT];
   wire lccf_src_t src = lccf_src_t'(cr1_q[`LCCF_CR1_SAMPLE]);
   wire lccf_cnt_t flt_cnt = cr0_q[`LCCF_CR0_CNT_MSB:`LCCF_CR0_CNT_LSB];

   assign comparator_enable = en;
   assign high_speed_mode = cr1_q[`LCCF_CR1_SPEED];
   assign window_mode = cr1_q[`LCCF_CR1_WINDOW];
   assign hysteresis_level = cr0_q[`LCCF_CR0_HYST];

   // ****************************************************************
   // Synchroniser and polarity
   // ****************************************************************
   logic sync1_q;
   logic sync2_q;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end
      else
      begin
         sync1_q <= raw_result;
         sync2_q <= sync1_q;
      end
   end

   wire logic sample_val = sync2_q ^ invert;

   // ****************************************************************
   // Sample timing
   // ****************************************************************
   lccf_byte_t per_cnt_q;
   wire logic period_off = (fpr_q == `LCCF_RESET_BYTE);
   wire logic period_tick = en && !period_off && (per_cnt_q == `LCCF_RESET_BYTE);
   wire logic sample_tick = (src == LCCF_SRC_STROBE) ? (en && sample_strobe)
                                                      : period_tick;
   // A zero count, or a zero period in period mode, bypasses the filter.
   wire logic bypass = (flt_cnt == `LCCF_CNT_OFF) || ((src == LCCF_SRC_PERIOD) && period_off);

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         per_cnt_q <= `LCCF_RESET_BYTE;
      else if (!en || period_off || period_tick)
         per_cnt_q <= fpr_q - 8'h01;
      else
         per_cnt_q <= per_cnt_q - 8'h01;
   end

   // ****************************************************************
   // Consecutive-sample filter
   // ****************************************************************
   lccf_cnt_t agree_q;
   lccf_cnt_t agree_d;
   logic cand_q;
   logic held_q;
   logic held_d;
   logic cand_d;
   lccf_cnt_t agree_inc;

   // Clearing the count on a sample that matches the held state keeps a glitch
   // from half-filling the counter for a later transition.
   always_comb
   begin
      agree_inc = (sample_val == cand_q) ? agree_q + `LCCF_CNT_ONE : `LCCF_CNT_ONE;
      agree_d = agree_q;
      cand_d = cand_q;
      held_d = held_q;
      if (sample_tick)
      begin
         if (sample_val == held_q)
            agree_d = `LCCF_CNT_OFF;
         else if (agree_inc >= flt_cnt)
         begin
            held_d = sample_val;
            agree_d = `LCCF_CNT_OFF;
         end
         else
         begin
            agree_d = agree_inc;
            cand_d = sample_val;
         end
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         agree_q <= `LCCF_CNT_OFF;
         cand_q <= 1'b0;
         held_q <= 1'b0;
      end
      else if (!en || bypass)
      begin
         agree_q <= `LCCF_CNT_OFF;
         cand_q <= 1'b0;
         held_q <= 1'b0;
      end
      else
      begin
         agree_q <= agree_d;
         cand_q <= cand_d;
         held_q <= held_d;
      end
   end

   logic out_q;
   logic out_d;

   // A zero count in strobe mode is an illegal setting that yields zero.
   always_comb
   begin
      if (!en)
         out_d = invert;
      else if (flt_cnt == `LCCF_CNT_OFF && src == LCCF_SRC_STROBE)
         out_d = 1'b0;
      else if (bypass)
         out_d = sample_val;
      else
         out_d = held_q;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         out_q <= 1'b0;
      else
         out_q <= out_d;
   end

   assign filtered_result = out_q;
   // The pin drive bit cannot be set, so the pin and status bit show the polarity bit.
   assign comparator_pin_output = invert;
   assign comparator_pin_oe = cr1_q[`LCCF_CR1_PIN_DRIVE];

   // ****************************************************************
   // Read mux and answer
   // ****************************************************************
   assign scr_rd = {7'b000_0000, invert};
   assign rd_byte = hit_cr0 ? cr0_q :
                    hit_cr1 ? cr1_q :
                    hit_fpr ? fpr_q :
                    hit_scr ? scr_rd : `LCCF_RESET_BYTE;
   assign prdata = {24'h00_0000, rd_byte};
   assign pready = 1'b1;
   assign pslverr = access && !hit_any;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_both_sel;
      @(posedge clk) disable iff (reset)
      (wr_cr1 && pwdata[7] && pwdata[6]) |=> (cr1_q[7] && !cr1_q[6]);
   endproperty
   a_both_sel: assert property (p_both_sel) else $error("both selects kept");

   property p_rsvd_zero;
      @(posedge clk) disable iff (reset)
      (access && !pwrite && hit_cr1) |-> (prdata[5] == 1'b0);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("bit 5 read nonzero");

   property p_speed;
      @(posedge clk) disable iff (reset)
      wr_cr1 |=> (high_speed_mode == $past(pwdata[4]));
   endproperty
   a_speed: assert property (p_speed) else $error("speed bit not taken");

   property p_pin_polarity;
      @(posedge clk) disable iff (reset)
      (access && !pwrite && hit_scr) |-> (prdata[0] == comparator_pin_output)
         && (comparator_pin_output == cr1_q[3]);
   endproperty
   a_pin_polarity: assert property (p_pin_polarity) else $error("polarity not shown");

   property p_no_drive;
      @(posedge clk) disable iff (reset)
      wr_cr1 |=> !comparator_pin_oe && !cr1_q[2];
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("stuck bits stored");

   property p_sync;
      @(posedge clk) disable iff (reset)
      $past(!reset, 2) |-> (sync2_q == $past(raw_result, 2));
   endproperty
   a_sync: assert property (p_sync) else $error("sync delay wrong");

   property p_off_clear;
      @(posedge clk) disable iff (reset)
      !en |=> (agree_q == 3'h0) && !held_q && (filtered_result == $past(invert));
   endproperty
   a_off_clear: assert property (p_off_clear) else $error("filter not cleared");

   // Leaving period mode cancels a pending wait, since no further tick is owed then.
   property p_period;
      @(posedge clk) disable iff (reset || !en || period_off || src != LCCF_SRC_PERIOD)
      (en && src == LCCF_SRC_PERIOD && !period_off && !wr_fpr && !wr_cr1)
         |-> ##[0:255] sample_tick;
   endproperty
   a_period: assert property (p_period) else $error("no periodic sample");

   property p_strobe;
      @(posedge clk) disable iff (reset)
      (en && src == LCCF_SRC_STROBE) |-> (sample_tick == sample_strobe);
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe not used");

   property p_held_tick;
      @(posedge clk) disable iff (reset)
      (en && !bypass && !$past(!en) && $changed(held_q)) |-> $past(sample_tick);
   endproperty
   a_held_tick: assert property (p_held_tick) else $error("held changed untimed");

   property p_held_hold;
      @(posedge clk) disable iff (reset)
      (en && !bypass && !sample_tick) |=> $stable(held_q);
   endproperty
   a_held_hold: assert property (p_held_hold) else $error("held moved without sample");

   property p_bypass;
      @(posedge clk) disable iff (reset)
      (en && src == LCCF_SRC_PERIOD && period_off)
         |=> (filtered_result == $past(sync2_q ^ invert));
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass output wrong");

   // An illegal zero count in strobe mode must not let the raw result through.
   property p_strobe_zero;
      @(posedge clk) disable iff (reset)
      (en && src == LCCF_SRC_STROBE && flt_cnt == `LCCF_CNT_OFF) |=> !filtered_result;
   endproperty
   a_strobe_zero: assert property (p_strobe_zero) else $error("zero count output set");

   c_both: cover property (@(posedge clk) wr_cr1 && pwdata[7] && pwdata[6]);
   c_accept: cover property (@(posedge clk) $rose(held_q));
   c_strobe: cover property (@(posedge clk) en && src == LCCF_SRC_STROBE && sample_strobe);
   c_unmapped: cover property (@(posedge clk) pslverr);
   c_period: cover property (@(posedge clk) period_tick && !bypass);

endmodule : lccf_ctrl

// file: hdl/lccf_consts.svh
/*
 * Register indices, field positions, reset values and filter limits of the
 * limit comparator control and filter block.
 * Assumes a 32-bit APB where byte address = 4 x register index.
 */
`ifndef LCCF_CONSTS_SVH
`define LCCF_CONSTS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define LCCF_IDX_CTRL_ZERO 14'h1879
`define LCCF_IDX_CTRL_ONE 14'h187A
`define LCCF_IDX_FILT_PER 14'h187B
`define LCCF_IDX_STAT_CTRL 14'h187C

// ****************************************************************
// Control register one fields
// ****************************************************************
`define LCCF_CR1_SAMPLE 7
`define LCCF_CR1_WINDOW 6
`define LCCF_CR1_RSVD 5
`define LCCF_CR1_SPEED 4
`define LCCF_CR1_INVERT 3
`define LCCF_CR1_SOURCE 2
`define LCCF_CR1_PIN_DRIVE 1
`define LCCF_CR1_ENABLE 0

// ****************************************************************
// Control register zero fields
// ****************************************************************
`define LCCF_CR0_CNT_LSB 4
`define LCCF_CR0_CNT_MSB 6
`define LCCF_CR0_HYST 0

// ****************************************************************
// Status register fields and reset values
// ****************************************************************
`define LCCF_SCR_OUT 0
`define LCCF_RESET_BYTE 8'h00
`define LCCF_CNT_OFF 3'h0
`define LCCF_CNT_ONE 3'h1

`endif

// file: hdl/lccf_pkg.sv
/*
 * Types of the limit comparator control and filter block.
 * Assumes lccf_consts.svh supplies the numeric constants.
 */
package lccf_pkg;

   typedef logic [7:0] lccf_byte_t;
   typedef logic [2:0] lccf_cnt_t;

   // Where filter samples come from.
   typedef enum logic {
      LCCF_SRC_PERIOD = 1'b0,
      LCCF_SRC_STROBE = 1'b1
   } lccf_src_t;

endpackage : lccf_pkg

// file: bench/testbench.sv
/*
 * Self-checking testbench for the limit comparator control and filter block.
 * Assumes lccf_consts.svh and lccf_pkg are compiled ahead of this file.
 */
`timescale 1ns/10ps
`include "lccf_consts.svh"

module testbench;
   import lccf_pkg::*;

   localparam logic [15:0] A_CR0 = {`LCCF_IDX_CTRL_ZERO, 2'b00};
   localparam logic [15:0] A_CR1 = {`LCCF_IDX_CTRL_ONE, 2'b00};
   localparam logic [15:0] A_FPR = {`LCCF_IDX_FILT_PER, 2'b00};
   localparam logic [15:0] A_SCR = {`LCCF_IDX_STAT_CTRL, 2'b00};

   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic raw_result = 1'b0;
   logic sample_strobe = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, f_out, pin_out, pin_oe, en, hs, win, hyst;
   logic [31:0] rd;
   logic err;
   int miscompares = 0;
   int n_checks = 0;

   always #5 clk = ~clk;

   lccf_ctrl #(.ADDR_W(16)) i_dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_result(raw_result),
      .sample_strobe(sample_strobe), .filtered_result(f_out),
      .comparator_pin_output(pin_out), .comparator_pin_oe(pin_oe),
      .comparator_enable(en), .high_speed_mode(hs), .window_mode(win),
      .hysteresis_level(hyst));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 16)
      begin
         miscompares++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'h1);
   endtask : wr

   task automatic rdc(input string what, input logic [15:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000, 4'h0);
      chk(what, exp, rd);
   endtask : rdc

   // Waits at most max cycles for the filtered output to reach exp.
   task automatic wait_out(input logic exp, input int max);
      for (int i = 0; i < max && f_out !== exp; i++)
         @(negedge clk);
      chk("filtered_result", 32'(exp), 32'(f_out));
   endtask : wait_out

   // The filtered output must keep exp for n cycles.
   task automatic hold_out(input logic exp, input int n);
      logic ok;
      ok = 1'b1;
      repeat (n)
      begin
         @(negedge clk);
         ok = ok & (f_out === exp);
      end
      chk("filtered_result held", 32'h1, 32'(ok));
   endtask : hold_out

   task automatic set_raw(input logic v);
      @(posedge clk);
      raw_result <= v;
   endtask : set_raw

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs();
      rdc("cr0 reset", A_CR0, 32'h0000_0000);
      rdc("cr1 reset", A_CR1, 32'h0000_0000);
      rdc("fpr reset", A_FPR, 32'h0000_0000);
      rdc("scr reset", A_SCR, 32'h0000_0000);
      wr(A_CR1, 32'hFFFF_FFFF);
      rdc("cr1 ones", A_CR1, 32'h0000_0099);
      chk("en hs win oe pin", 32'h0000_0019, 32'({en, hs, win, pin_oe, pin_out}));
      rdc("scr out", A_SCR, 32'h0000_0001);
      wr(A_CR1, 32'h0000_0040);
      rdc("cr1 window", A_CR1, 32'h0000_0040);
      chk("en hs win pin", 32'h0000_0002, 32'({en, hs, win, pin_out}));
      wr(A_SCR, 32'h0000_00FF);
      rdc("scr write", A_SCR, 32'h0000_0000);
      wr(A_CR0, 32'h0000_00FF);
      rdc("cr0 ones", A_CR0, 32'h0000_0071);
      chk("hysteresis_level", 32'h1, 32'(hyst));
      wr(A_FPR, 32'hFFFF_FFA5);
      rdc("fpr", A_FPR, 32'h0000_00A5);
      apb(1'b1, A_FPR, 32'h0000_0000, 4'h0);
      rdc("fpr no strobe", A_FPR, 32'h0000_00A5);
      apb(1'b0, 16'h6200, 32'h0000_0000, 4'h0);
      chk("unmapped err", 32'h0000_0001, 32'({rd != 32'h0, err}));
      wr(A_CR1, 32'h0000_0000);
      $display("Test registers done");
   endtask : t_regs

   task automatic t_bypass();
      wr(A_CR0, 32'h0000_0000);
      wr(A_FPR, 32'h0000_0000);
      wr(A_CR1, 32'h0000_0001);
      set_raw(1'b1);
      @(negedge clk);
      chk("sync delay", 32'h0, 32'(f_out));
      wait_out(1'b1, 6);
      wr(A_CR1, 32'h0000_0009);
      wait_out(1'b0, 6);
      wr(A_CR1, 32'h0000_0008);
      wait_out(1'b1, 4);
      chk("pin output", 32'h1, 32'(pin_out));
      rdc("scr disabled", A_SCR, 32'h0000_0001);
      set_raw(1'b0);
      wr(A_CR1, 32'h0000_0000);
      $display("Test bypass done");
   endtask : t_bypass

   task automatic t_filter(input logic [2:0] cnt, input logic [7:0] per, input int gl);
      wr(A_CR0, 32'({cnt, 4'h0}));
      wr(A_FPR, 32'(per));
      wr(A_CR1, 32'h0000_0001);
      wait_out(1'b0, 10);
      set_raw(1'b1);
      repeat (gl) @(posedge clk);
      raw_result <= 1'b0;
      hold_out(1'b0, 20);
      set_raw(1'b1);
      wait_out(1'b1, 60);
      set_raw(1'b0);
      wr(A_CR1, 32'h0000_0000);
      $display("Test filter count %0d period %0d done", cnt, per);
   endtask : t_filter

   task automatic t_strobe();
      wr(A_CR0, 32'h0000_0010);
      wr(A_CR1, 32'h0000_0081);
      set_raw(1'b1);
      hold_out(1'b0, 15);
      @(posedge clk);
      sample_strobe <= 1'b1;
      wait_out(1'b1, 8);
      wr(A_CR0, 32'h0000_0000);
      wait_out(1'b0, 6);
      set_raw(1'b0);
      sample_strobe <= 1'b0;
      wr(A_CR1, 32'h0000_0000);
      $display("Test strobe done");
   endtask : t_strobe

   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_bypass();
      t_filter(3'd2, 8'd1, 1);
      t_filter(3'd4, 8'd1, 3);
      t_filter(3'd7, 8'd1, 6);
      t_filter(3'd2, 8'd5, 3);
      t_strobe();
      complete_run();
   end

endmodule : testbench
